//--- design/aux_status_ctrl.sv
// Purpose: Auxiliary control and auxiliary status registers with jabber control
// Assumes: Negotiation and link inputs are on clk; transmit request is not
// Notes: Status latches update on the edge after a status read
//
// Overview of operation
// [R1] Writing one to control bit 15 disables jabber detection.
// [R2] Writing zero there, or reset, re-enables jabber detection.
// [R3] Reading control bit 15 returns its stored value.
// [R4] Enabled 10 Mb/s jabber shuts the transmitter after maximum request time.
// [R5] Software sets the power-saving bit to lower consumption.
// [R6] Status bit 15 shows negotiation complete, zero when negotiation disabled.
// [R7] Status bit 14 latches acknowledge completion until read.
// [R8] Status bit 13 latches acknowledge match entry until read.
// [R9] Status bit 12 latches ability detect state until read.
// [R10] Status bit 11 shows pause after completion with symmetric pause both sides.
// [R11] Bits 10:8 report resolved common mode with the five legal codes.
// [R12] Status bit 7 latches parallel detection fault, re-evaluated on read.
// [R13] Status bit 6 latches remote fault until read finds it gone.
// [R14] Status bit 5 latches code word received, re-evaluated on read.
// [R15] Status bit 4 shows partner negotiation ability, updated on read.
// [R16] Status bit 3 shows one at 100 Mb/s, zero at 10 Mb/s.
// [R17] Status bit 2 clears on link failure, sets on read with valid link.
// [R18] Status bit 1 mirrors negotiation enable unless fiber mode.
// [R19] Status bit 0 latches jabber until read, zero at 100 Mb/s.
// [R20] Status writes ignored; reads return fields then apply latch updates.
module aux_status_ctrl
  import aux_status_pkg::*;
#(
  parameter int unsigned JABBER_CYCLES = JABBER_CYCLES_DEF
) (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Management pins
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  input wire logic [4:0] phyAddr,
  // Negotiation, link and fault inputs
  input an_status_t an,
  // Transmit path
  input wire logic txEnable,
  output logic txShutoff,
  // Control outputs
  output logic mgmtPowerSave,
  output logic jabberDisabled
);
  typedef struct packed {
    logic jabberDisable;
    logic ctlRsv14;
    logic [2:0] ctlRsv;
    logic powerSave;
    logic ackLatch;
    logic detectLatch;
    logic abilityLatch;
    logic pdFaultLatch;
    logic remoteLatch;
    logic pageLatch;
    logic lpAble;
    logic linkUp;
    logic jabberLatch;
  } aux_q_t;

  aux_q_t q, d;
  mgmt_req_t req;
  logic [15:0] rdData;
  logic [15:0] statusWord;
  logic [15:0] ctrlWord;
  logic [2:0] modeField;
  logic anOn;
  logic remoteNow;
  logic jabberNow;
  logic rdStatus;
  logic wrCtrl;
  logic wrStatus;
  logic rdCtrl;
  logic jabEnable;

  function automatic logic [2:0] legal_mode(input logic [2:0] m);
    logic [2:0] r;
    r = MODE_NONE;
    if (m == MODE_10_HALF || m == MODE_10_FULL || m == MODE_100_HALF || m == MODE_100_FULL) begin
      r = m;
    end
    return r;
  endfunction : legal_mode

  mdio_frame_slave u_mdio (
    .clk(clk),
    .sys_rst(sys_rst),
    .mdc(mdc),
    .mdioIn(mdioIn),
    .mdioOut(mdioOut),
    .mdioOe(mdioOe),
    .phyAddr(phyAddr),
    .req(req),
    .rdData(rdData)
  );

  // [R4] Watchdog only in 10 Mb/s
  assign jabEnable = ~q.jabberDisable & ~an.speedHundredFlag;

  jabber_timer #(
    .JABBER_CYCLES(JABBER_CYCLES)
  ) u_jabber (
    .clk(clk),
    .sys_rst(sys_rst),
    .enable(jabEnable),
    .txEnable(txEnable),
    .txShutoff(txShutoff)
  );

  assign jabberNow = txShutoff;
  assign rdStatus = req.rdStrobe && req.addr == REG_AUX_STATUS;
  assign rdCtrl = req.rdStrobe && req.addr == REG_AUX_CTRL;
  assign wrCtrl = req.wrStrobe && req.addr == REG_AUX_CTRL;
  assign wrStatus = req.wrStrobe && req.addr == REG_AUX_STATUS;
  // [R18] Enable unless fiber
  assign anOn = an.anEnableCtl & ~an.fiberMode;
  assign remoteNow = an.partnerRemoteFault | an.farEndFault;
  // [R11] Only legal mode codes
  assign modeField = legal_mode(an.resolvedCommonMode);

  // [R3] Control readback
  assign ctrlWord = {q.jabberDisable, q.ctlRsv14, 6'h00, q.ctlRsv, q.powerSave, CTL_LOW_FIXED};

  // [R6] Complete gated by enable
  // [R10] Pause after completion only
  // [R16] Speed straight through
  assign statusWord = {
    an.anComplete & anOn,
    q.ackLatch,
    q.detectLatch,
    q.abilityLatch,
    an.anComplete & an.localSymPause & an.partnerSymPause,
    modeField,
    q.pdFaultLatch,
    q.remoteLatch,
    q.pageLatch,
    q.lpAble,
    an.speedHundredFlag,
    q.linkUp,
    anOn,
    q.jabberLatch
  };

  // [R20] Read returns current fields
  assign rdData = rdStatus ? statusWord : (rdCtrl ? ctrlWord : 16'h0000);

  always_comb begin
    d = q;
    // [R1] Store jabber disable
    // [R2] Zero restores detection
    // [R5] Power-saving stored, driven out on mgmtPowerSave
    // [R20] Status writes do nothing
    if (wrCtrl) begin
      d.jabberDisable = req.wdata[CTL_JAB_DIS_BIT];
      d.ctlRsv14 = req.wdata[14];
      d.ctlRsv = req.wdata[7:5];
      d.powerSave = req.wdata[CTL_PWR_SAVE_BIT];
    end
    // [R7] Sticky ack complete, set wins
    d.ackLatch = (rdStatus ? 1'b0 : q.ackLatch) | an.ackDone;
    // [R8] Sticky ack match
    d.detectLatch = (rdStatus ? 1'b0 : q.detectLatch) | an.ackMatch;
    // [R9] Sticky ability detect
    d.abilityLatch = (rdStatus ? 1'b0 : q.abilityLatch) | an.abilityDetect;
    // [R12] Sticky parallel fault
    d.pdFaultLatch = (rdStatus ? 1'b0 : q.pdFaultLatch) | an.pdFault;
    // [R13] Sticky remote fault
    d.remoteLatch = (rdStatus ? 1'b0 : q.remoteLatch) | remoteNow;
    // [R14] Sticky page received
    d.pageLatch = (rdStatus ? 1'b0 : q.pageLatch) | an.codeWordRcvd;
    // [R15] Sample partner ability on read
    if (rdStatus) begin
      d.lpAble = an.partnerAnAble;
    end
    // [R17] Drop at once, raise on read
    if (!an.linkValid) begin
      d.linkUp = 1'b0;
    end else if (rdStatus) begin
      d.linkUp = 1'b1;
    end
    // [R19] Sticky jabber, forced low at 100 Mb/s
    if (an.speedHundredFlag) begin
      d.jabberLatch = 1'b0;
    end else begin
      d.jabberLatch = (rdStatus ? 1'b0 : q.jabberLatch) | jabberNow;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.ctlRsv <= CTL_RSV_RESET;
    end else begin
      q <= d;
    end
  end

  assign mgmtPowerSave = q.powerSave;
  assign jabberDisabled = q.jabberDisable;

  a_jab_disable_set: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
    wrCtrl && req.wdata[CTL_JAB_DIS_BIT] |=> jabberDisabled && !jabEnable)
    else $error("jabber disable not taken");

  a_jab_enable_set: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
    wrCtrl && !req.wdata[CTL_JAB_DIS_BIT] |=> !jabberDisabled)
    else $error("jabber enable not taken");

  a_ctrl_read_back: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
    rdCtrl |-> rdData[CTL_JAB_DIS_BIT] == q.jabberDisable && rdData[3:0] == CTL_LOW_FIXED)
    else $error("control readback wrong");

  a_jab_gate_off: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
    jabberDisabled ##1 jabberDisabled |-> !txShutoff)
    else $error("shutoff while jabber disabled");

  a_pwr_save_hold: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
    !wrCtrl |=> $stable(mgmtPowerSave))
    else $error("power save changed without write");

  a_an_done_gate: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
    statusWord[15] |-> an.anComplete && an.anEnableCtl && !an.fiberMode)
    else $error("complete shown while negotiation off");

  a_ack_sticky: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
    (q.ackLatch && !rdStatus) || an.ackDone |=> statusWord[14])
    else $error("ack complete latch lost");

  a_detect_sticky: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
    an.ackMatch ##1 !rdStatus [*2] |=> statusWord[13])
    else $error("ack match latch lost");

  a_ability_clear: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
    rdStatus && !an.abilityDetect |=> !statusWord[12])
    else $error("ability latch not cleared by read");

  a_pause_needs_both: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    statusWord[11] |-> an.anComplete && an.localSymPause && an.partnerSymPause)
    else $error("pause shown without both sides");

  a_mode_legal: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
    statusWord[10:8] != 3'h4 && statusWord[10:8] != 3'h6 && statusWord[10:8] != 3'h7)
    else $error("illegal mode code shown");

  a_pd_fault_eval: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
    rdStatus |=> statusWord[7] == $past(an.pdFault))
    else $error("parallel fault not re-evaluated");

  a_remote_hold: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
    q.remoteLatch && rdStatus && remoteNow |=> statusWord[6])
    else $error("remote fault cleared while present");

  a_page_eval: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
    an.codeWordRcvd |=> statusWord[5])
    else $error("page received not latched");

  a_lp_update: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
    rdStatus |=> statusWord[4] == $past(an.partnerAnAble))
    else $error("partner ability not sampled on read");

  a_lp_hold: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
    !rdStatus |=> $stable(statusWord[4]))
    else $error("partner ability moved without read");

  a_speed_bit: assert property (@(posedge clk) disable iff (sys_rst) // [R16]
    statusWord[3] == an.speedHundredFlag)
    else $error("speed bit wrong");

  a_link_drop: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
    !an.linkValid |=> !statusWord[2])
    else $error("link bit not cleared on failure");

  a_link_stay_low: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
    !q.linkUp && !rdStatus |=> !q.linkUp)
    else $error("link bit rose without read");

  a_an_enable_bit: assert property (@(posedge clk) disable iff (sys_rst) // [R18]
    statusWord[1] == (an.anEnableCtl && !an.fiberMode))
    else $error("negotiation enable bit wrong");

  a_jab_fast_zero: assert property (@(posedge clk) disable iff (sys_rst) // [R19]
    an.speedHundredFlag |=> !statusWord[0])
    else $error("jabber shown at 100 Mb/s");

  a_jab_latch_hold: assert property (@(posedge clk) disable iff (sys_rst) // [R19]
    q.jabberLatch && !rdStatus && !an.speedHundredFlag |=> q.jabberLatch)
    else $error("jabber latch lost without read");

  a_status_no_write: assert property (@(posedge clk) disable iff (sys_rst) // [R20]
    wrStatus |=> $stable(q.jabberDisable) && $stable(q.powerSave) && $stable(q.ctlRsv))
    else $error("status write changed control");

  a_other_reg_zero: assert property (@(posedge clk) disable iff (sys_rst) // [R20]
    req.rdStrobe && !rdStatus && !rdCtrl |-> rdData == 16'h0000)
    else $error("unmapped register read not zero");

  a_jab_shut_speed: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
    an.speedHundredFlag |=> !txShutoff)
    else $error("shutoff held at 100 Mb/s");

  a_pwr_save_write: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
    wrCtrl |=> mgmtPowerSave == $past(req.wdata[CTL_PWR_SAVE_BIT]))
    else $error("power save not stored");

  a_ack_clear: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
    rdStatus && !an.ackDone |=> !statusWord[14])
    else $error("ack latch not cleared by read");

  a_detect_clear: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
    rdStatus && !an.ackMatch |=> !statusWord[13])
    else $error("ack match latch not cleared by read");

  a_ability_set: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
    an.abilityDetect |=> statusWord[12])
    else $error("ability detect not latched");

  a_pd_fault_set: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
    an.pdFault |=> statusWord[7])
    else $error("parallel fault not latched");

  a_remote_clear: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
    rdStatus && !remoteNow |=> !statusWord[6])
    else $error("remote fault kept after clean read");

  a_page_clear: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
    rdStatus && !an.codeWordRcvd |=> !statusWord[5])
    else $error("page latch not cleared by read");

  a_link_rise_read: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
    $rose(q.linkUp) |-> $past(rdStatus) && $past(an.linkValid))
    else $error("link bit rose without valid read");

  a_jab_latch_set: assert property (@(posedge clk) disable iff (sys_rst) // [R19]
    jabberNow && !an.speedHundredFlag |=> statusWord[0])
    else $error("jabber not latched");

  a_jab_unlatch: assert property (@(posedge clk) disable iff (sys_rst) // [R19]
    rdStatus && !jabberNow |=> !statusWord[0])
    else $error("jabber latch kept after clean read");
endmodule : aux_status_ctrl

//--- design/aux_status_pkg.sv
// Purpose: Shared constants and carriers for the auxiliary status block
// Assumes: 25 MHz system clock, management frames over a serial port
// Notes: Register addresses are management register numbers
package aux_status_pkg;
  localparam logic [4:0] REG_AUX_CTRL = 5'h18;
  localparam logic [4:0] REG_AUX_STATUS = 5'h19;
  localparam int CTL_JAB_DIS_BIT = 15;
  localparam int CTL_PWR_SAVE_BIT = 4;
  localparam logic [2:0] CTL_RSV_RESET = 3'h1;
  localparam logic [3:0] CTL_LOW_FIXED = 4'h7;
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_10_HALF = 3'h1;
  localparam logic [2:0] MODE_10_FULL = 3'h2;
  localparam logic [2:0] MODE_100_HALF = 3'h3;
  localparam logic [2:0] MODE_100_FULL = 3'h5;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [4:0] HDR_BITS = 5'h0C;
  localparam logic [4:0] DATA_BITS = 5'h10;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned JABBER_TIME_MS = 20;
  localparam int unsigned JABBER_CYCLES_DEF = JABBER_TIME_MS * (CLK_HZ / 1000);
  localparam int JAB_CNT_W = 20;

  // Outputs of the negotiation, link and fault logic
  typedef struct packed {
    logic anEnableCtl;
    logic fiberMode;
    logic anComplete;
    logic ackDone;
    logic ackMatch;
    logic abilityDetect;
    logic localSymPause;
    logic partnerSymPause;
    logic [2:0] resolvedCommonMode;
    logic pdFault;
    logic partnerRemoteFault;
    logic farEndFault;
    logic codeWordRcvd;
    logic partnerAnAble;
    logic speedHundredFlag;
    logic linkValid;
  } an_status_t;

  // One decoded management access
  typedef struct packed {
    logic rdStrobe;
    logic wrStrobe;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mgmt_req_t;
endpackage : aux_status_pkg

//--- design/jabber_timer.sv
// Purpose: Transmit jabber watchdog for 10 Mb/s operation
// Assumes: Transmit request arrives from another clock domain
// Notes: Shutoff holds until the request drops or enable goes low
module jabber_timer
  import aux_status_pkg::*;
#(
  parameter int unsigned JABBER_CYCLES = JABBER_CYCLES_DEF
) (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Control and request
  input wire logic enable,
  input wire logic txEnable,
  // Result
  output logic txShutoff
);
  localparam logic [JAB_CNT_W-1:0] JAB_LAST = JAB_CNT_W'(JABBER_CYCLES - 1);

  typedef struct packed {
    logic [1:0] txSync;
    logic [JAB_CNT_W-1:0] cnt;
    logic shutoff;
  } jab_q_t;

  jab_q_t q, d;

  always_comb begin
    d = q;
    d.txSync = {q.txSync[0], txEnable};
    if (!enable || !q.txSync[1]) begin
      d.cnt = '0;
      d.shutoff = 1'b0;
    // [R4] Trip after max time
    end else if (!q.shutoff) begin
      if (q.cnt == JAB_LAST) begin
        d.shutoff = 1'b1;
      end else begin
        d.cnt = q.cnt + JAB_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign txShutoff = q.shutoff;

  a_jab_trip_time: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
    $rose(q.shutoff) |-> $past(q.cnt) == JAB_LAST && $past(enable))
    else $error("jabber shutoff without full count");
endmodule : jabber_timer

//--- design/mdio_frame_slave.sv
// Purpose: Serial management frame slave, one strobe per access
// Assumes: MDC well below the system clock, preamble optional
// Notes: Read data is captured at the end of the read strobe cycle
module mdio_frame_slave
  import aux_status_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Management pins
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  input wire logic [4:0] phyAddr,
  // Register side
  output mgmt_req_t req,
  input wire logic [15:0] rdData
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_HDR = 3'b001,
    S_RTA = 3'b010,
    S_RDATA = 3'b011,
    S_WSKIP = 3'b100
  } frame_state_t;

  typedef struct packed {
    logic [1:0] mdcSync;
    logic [1:0] mdioSync;
    logic mdcLast;
    logic lastBit;
    frame_state_t st;
    logic [4:0] cnt;
    logic [15:0] shift;
    logic isWrite;
    logic out;
    logic oe;
    mgmt_req_t req;
  } mdio_q_t;

  mdio_q_t q, d;
  logic rise;
  logic bitIn;
  logic [15:0] shiftIn;

  assign rise = q.mdcSync[1] & ~q.mdcLast;
  assign bitIn = q.mdioSync[1];
  assign shiftIn = {q.shift[14:0], bitIn};

  always_comb begin
    d = q;
    d.mdcSync = {q.mdcSync[0], mdc};
    d.mdioSync = {q.mdioSync[0], mdioIn};
    d.mdcLast = q.mdcSync[1];
    d.req.rdStrobe = 1'b0;
    d.req.wrStrobe = 1'b0;
    if (q.req.rdStrobe) begin
      d.shift = rdData;
    end
    if (rise) begin
      d.lastBit = bitIn;
      unique case (q.st)
        S_IDLE: begin
          if (!q.lastBit && bitIn) begin
            d.st = S_HDR;
            d.cnt = 5'h00;
          end
        end
        S_HDR: begin
          d.shift = shiftIn;
          d.cnt = q.cnt + 5'h01;
          if (q.cnt == HDR_BITS - 5'h01) begin
            d.cnt = 5'h00;
            d.req.addr = shiftIn[4:0];
            d.isWrite = shiftIn[11:10] == OP_WRITE && shiftIn[9:5] == phyAddr;
            if (shiftIn[11:10] == OP_READ && shiftIn[9:5] == phyAddr) begin
              d.st = S_RTA;
              d.req.rdStrobe = 1'b1;
            end else begin
              d.st = S_WSKIP;
            end
          end
        end
        S_RTA: begin
          d.oe = 1'b1;
          d.out = 1'b0;
          d.st = S_RDATA;
        end
        S_RDATA: begin
          if (q.cnt == DATA_BITS) begin
            d.oe = 1'b0;
            d.out = 1'b0;
            d.lastBit = 1'b1;
            d.st = S_IDLE;
          end else begin
            d.out = q.shift[15];
            d.shift = {q.shift[14:0], 1'b0};
            d.cnt = q.cnt + 5'h01;
          end
        end
        S_WSKIP: begin
          d.shift = shiftIn;
          d.cnt = q.cnt + 5'h01;
          if (q.cnt == DATA_BITS + 5'h01) begin
            d.req.wrStrobe = q.isWrite;
            d.req.wdata = shiftIn;
            d.lastBit = 1'b1;
            d.st = S_IDLE;
          end
        end
        default: d.st = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.lastBit <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign req = q.req;
  assign mdioOut = q.out;
  assign mdioOe = q.oe;
endmodule : mdio_frame_slave

//--- test/mdio_station.sv
// Purpose: Station management model driving MDC and the data line
// Assumes: MDC of 17 clk periods, line pulled up when nobody drives
// Notes: MDC stands low between frames
module mdio_station
  import aux_status_pkg::*;
(
  // System
  input wire logic clk,
  // Management pins
  output logic mdc,
  output logic staOut,
  output logic staOe,
  input wire logic mdioLine,
  input wire logic [4:0] phyAddr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    mdc = 1'b0;
    staOut = 1'b1;
    staOe = 1'b0;
  end

  // Two preamble ones, then the 32-bit frame; read data sampled on rises 18..33
  task automatic frame(input logic [1:0] op, input logic [4:0] regNum, input logic [15:0] wdata,
                       output logic [15:0] rdata);
    logic [31:0] bits;
    bits = {2'b01, op, phyAddr, regNum, 2'b10, wdata};
    rdata = 16'h0000;
    for (int i = 0; i < 34; i++) begin
      @(negedge clk);
      staOe = (i < 16) || (op == OP_WRITE);
      staOut = (i < 2) ? 1'b1 : bits[33 - i];
      repeat (8) @(negedge clk);
      mdc = 1'b1;
      if (i >= 18) begin
        rdata = {rdata[14:0], mdioLine};
      end
      repeat (8) @(negedge clk);
      mdc = 1'b0;
    end
    staOe = 1'b0;
  endtask : frame
endmodule : mdio_station

//--- test/testbench.sv
// Purpose: Self-checking bench for the auxiliary status block
// Assumes: Short jabber count, management frames from the station model
// Notes: Inputs change on the falling clock edge
module testbench
  import aux_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned JAB = 20;
  logic clk, sys_rst, mdc, mdioOut, mdioOe, staOut, staOe, mdioLine;
  logic txEnable, txShutoff, mgmtPowerSave, jabberDisabled;
  logic [4:0] phyAddr, staPhy;
  logic [15:0] rd;
  logic [2:0] em;
  an_status_t an, ev;
  int mismatches, cmpCount;

  // Pull-up on the shared data line
  assign mdioLine = mdioOe ? mdioOut : (staOe ? staOut : 1'b1);

  aux_status_ctrl #(.JABBER_CYCLES(JAB)) u_dut (.clk(clk), .sys_rst(sys_rst), .mdc(mdc), .mdioIn(mdioLine),
    .mdioOut(mdioOut), .mdioOe(mdioOe), .phyAddr(phyAddr), .an(an), .txEnable(txEnable),
    .txShutoff(txShutoff), .mgmtPowerSave(mgmtPowerSave), .jabberDisabled(jabberDisabled));
  mdio_station u_sta (.clk(clk), .mdc(mdc), .staOut(staOut), .staOe(staOe), .mdioLine(mdioLine),
    .phyAddr(staPhy));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_reg(input logic [4:0] r, output logic [15:0] v);
    u_sta.frame(OP_READ, r, 16'h0000, v);
    repeat (4) @(negedge clk);
  endtask : rd_reg

  task automatic wr_reg(input logic [4:0] r, input logic [15:0] v);
    logic [15:0] unused;
    u_sta.frame(OP_WRITE, r, v, unused);
    repeat (4) @(negedge clk);
  endtask : wr_reg

  task automatic rchk(input logic [4:0] r, input logic [15:0] mask, input logic [15:0] exp);
    logic [15:0] v;
    rd_reg(r, v);
    check(v & mask, exp);
  endtask : rchk

  task automatic done(input string name);
    $display("Test %s finished", name);
  endtask : done

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin : watchdog
    repeat (60000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    sys_rst = 1'b1;
    an = '0;
    txEnable = 1'b0;
    phyAddr = 5'h05;
    staPhy = 5'h05;
    mismatches = 0;
    cmpCount = 0;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    check({13'h0, jabberDisabled, mgmtPowerSave, txShutoff}, 16'h0000);
    rchk(REG_AUX_CTRL, 16'hFFFF, 16'h0027);
    rchk(REG_AUX_STATUS, 16'hFFFF, 16'h0000);
    done("reset");
    wr_reg(REG_AUX_CTRL, 16'h8010);
    check({14'h0, jabberDisabled, mgmtPowerSave}, 16'h0003);
    rchk(REG_AUX_CTRL, 16'hFFFF, 16'h8017);
    txEnable = 1'b1;
    repeat (JAB + 10) @(negedge clk);
    check({15'h0, txShutoff}, 16'h0000);
    txEnable = 1'b0;
    wr_reg(REG_AUX_CTRL, 16'h0000);
    check({15'h0, jabberDisabled}, 16'h0000);
    rchk(REG_AUX_CTRL, 16'hFFFF, 16'h0007);
    done("control");
    txEnable = 1'b1;
    repeat (JAB - 2) @(negedge clk);
    check({15'h0, txShutoff}, 16'h0000);
    repeat (10) @(negedge clk);
    check({15'h0, txShutoff}, 16'h0001);
    txEnable = 1'b0;
    repeat (5) @(negedge clk);
    check({15'h0, txShutoff}, 16'h0000);
    rchk(REG_AUX_STATUS, 16'h0001, 16'h0001);
    rchk(REG_AUX_STATUS, 16'h0001, 16'h0000);
    an.speedHundredFlag = 1'b1;
    txEnable = 1'b1;
    repeat (JAB + 10) @(negedge clk);
    check({15'h0, txShutoff}, 16'h0000);
    rchk(REG_AUX_STATUS, 16'h0009, 16'h0008);
    txEnable = 1'b0;
    an.speedHundredFlag = 1'b0;
    rchk(REG_AUX_STATUS, 16'h0008, 16'h0000);
    done("jabber");
    an.anEnableCtl = 1'b1;
    an.anComplete = 1'b1;
    an.localSymPause = 1'b1;
    an.partnerSymPause = 1'b1;
    for (int m = 0; m < 8; m++) begin
      an.resolvedCommonMode = 3'(m);
      em = (3'(m) inside {MODE_NONE, MODE_10_HALF, MODE_10_FULL, MODE_100_HALF, MODE_100_FULL}) ? 3'(m) : MODE_NONE;
      rchk(REG_AUX_STATUS, 16'h8F02, {1'b1, 3'h0, 1'b1, em, 6'h00, 1'b1, 1'b0});
    end
    an.partnerSymPause = 1'b0;
    rchk(REG_AUX_STATUS, 16'h8802, 16'h8002);
    an.fiberMode = 1'b1;
    rchk(REG_AUX_STATUS, 16'h8802, 16'h0000);
    an.fiberMode = 1'b0;
    an.anEnableCtl = 1'b0;
    rchk(REG_AUX_STATUS, 16'h8802, 16'h0000);
    done("static");
    ev = '0;
    ev.ackDone = 1'b1;
    ev.ackMatch = 1'b1;
    ev.abilityDetect = 1'b1;
    ev.pdFault = 1'b1;
    ev.codeWordRcvd = 1'b1;
    ev.farEndFault = 1'b1;
    an = an | ev;
    @(negedge clk);
    an = an & ~ev;
    rchk(REG_AUX_STATUS, 16'h70E0, 16'h70E0);
    rchk(REG_AUX_STATUS, 16'h70E0, 16'h0000);
    an.partnerRemoteFault = 1'b1;
    rchk(REG_AUX_STATUS, 16'h0040, 16'h0040);
    rchk(REG_AUX_STATUS, 16'h0040, 16'h0040);
    an.partnerRemoteFault = 1'b0;
    rchk(REG_AUX_STATUS, 16'h0040, 16'h0040);
    rchk(REG_AUX_STATUS, 16'h0040, 16'h0000);
    done("latched");
    an.partnerAnAble = 1'b1;
    rd_reg(REG_AUX_STATUS, rd);
    rchk(REG_AUX_STATUS, 16'h0010, 16'h0010);
    an.partnerAnAble = 1'b0;
    rd_reg(REG_AUX_STATUS, rd);
    rchk(REG_AUX_STATUS, 16'h0010, 16'h0000);
    an.linkValid = 1'b1;
    rd_reg(REG_AUX_STATUS, rd);
    rchk(REG_AUX_STATUS, 16'h0004, 16'h0004);
    an.linkValid = 1'b0;
    @(negedge clk);
    an.linkValid = 1'b1;
    rchk(REG_AUX_STATUS, 16'h0004, 16'h0000);
    rchk(REG_AUX_STATUS, 16'h0004, 16'h0004);
    done("partner and link");
    an = '0;
    rd_reg(REG_AUX_STATUS, rd);
    wr_reg(REG_AUX_STATUS, 16'hFFFF);
    rchk(REG_AUX_STATUS, 16'hFFFF, 16'h0000);
    rchk(REG_AUX_CTRL, 16'hFFFF, 16'h0007);
    rchk(5'h1F, 16'hFFFF, 16'h0000);
    staPhy = 5'h06;
    rchk(REG_AUX_CTRL, 16'hFFFF, 16'hFFFF);
    wr_reg(REG_AUX_CTRL, 16'h8000);
    staPhy = 5'h05;
    check({15'h0, jabberDisabled}, 16'h0000);
    done("refused");
    report_and_stop();
  end
endmodule : testbench
